// *** design/quad_spi_read_controller.sv ***
`timescale 1ns/10ps
// Function
// - Controller only, drives clock and select
// - Reads one, two or four lines
// - Words delivered to software, no bit handling
// - Word length one to 128 bits
// - One to 4096 words per select frame
// - Optional word or frame completion event
// - Zero to three clocks before data
// - Zero or odd divide gives half duty
// - Even divide gives D/2 over D+1
// - Clock mode 0, idle low
// - Sample read data on falling edge
module quad_spi_read_controller
#(
    parameter int FIFO_WORDS = qspi_pkg::FIFO_DEPTH
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [1:0] read_width_i,
    input wire logic [qspi_pkg::LEN_W-1:0] word_len_m1_i,
    input wire logic [qspi_pkg::CNT_W-1:0] word_cnt_m1_i,
    input wire logic [qspi_pkg::DLY_W-1:0] cs_delay_i,
    input wire logic [qspi_pkg::DIV_W-1:0] serial_clock_divide_factor_i,
    input wire logic word_irq_en_i,
    input wire logic frame_irq_en_i,
    output logic busy_o,
    output logic word_irq_o,
    output logic frame_irq_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [qspi_pkg::WORD_W-1:0] rd_data_o,
    output logic sclk_o,
    output logic cs_b_o,
    input wire logic [3:0] dq_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    qspi_pkg::seq_state_e state;
    qspi_pkg::seq_state_e next_state;
    qspi_pkg::frame_cfg_s cfg;
    logic [qspi_pkg::PH_W-1:0] ph;
    logic [qspi_pkg::BIT_W-1:0] bit_cnt;
    logic [qspi_pkg::CNT_W-1:0] word_cnt;
    logic [qspi_pkg::DLY_W-1:0] lead_cnt;
    logic [qspi_pkg::WORD_W-1:0] shreg;
    logic sclk;
    logic cs_b;
    logic word_irq;
    logic frame_irq;
    logic push_ready;

    // ------------------------------------------------------------------
    // Divider decode
    // ------------------------------------------------------------------
    // Period is D+1 module clocks, two for D=0; low phase takes the odd extra cycle
    wire [qspi_pkg::PH_W-1:0] div_p1 = {1'b0, cfg.div} + 9'h001;
    wire [qspi_pkg::PH_W-1:0] period =
        (cfg.div == '0) ? qspi_pkg::MIN_PERIOD : div_p1;
    // nonzero even divide, low phase one longer
    wire [qspi_pkg::PH_W-1:0] high_len = period >> 1;
    wire [qspi_pkg::PH_W-1:0] low_len = period - high_len;
    wire ph_wrap = (ph == period - 9'h001);
    wire [qspi_pkg::PH_W-1:0] ph_nxt = ph_wrap ? '0 : ph + 9'h001;

    // ------------------------------------------------------------------
    // Lane and word decode
    // ------------------------------------------------------------------
    wire is_idle = (state == qspi_pkg::ST_IDLE);
    wire is_lead = (state == qspi_pkg::ST_LEAD);
    wire is_shift = (state == qspi_pkg::ST_SHIFT);
    wire is_push = (state == qspi_pkg::ST_PUSH);
    wire start_ok = is_idle && start_i;
    wire single = (cfg.width == qspi_pkg::WIDTH_SINGLE);
    wire dual = (cfg.width == qspi_pkg::WIDTH_DUAL);
    wire [qspi_pkg::BIT_W-1:0] step = single ? 8'h01 : (dual ? 8'h02 : 8'h04);
    wire [qspi_pkg::BIT_W-1:0] word_bits = {1'b0, cfg.word_len_m1} + 8'h01;
    // Falling sclk edge: the only point where read data are taken
    wire sample_now = is_shift && ph_wrap;
    wire word_end = sample_now && (bit_cnt + step >= word_bits);
    wire last_word = (word_cnt == cfg.word_cnt_m1);
    wire push_done = is_push && push_ready;
    wire [3:0] lanes = single ? {3'h0, dq_i[1]}
                     : (dual ? {2'h0, dq_i[1:0]} : dq_i);
    wire [qspi_pkg::WORD_W-1:0] shifted = single ? {shreg[126:0], lanes[0]}
        : (dual ? {shreg[125:0], lanes[1:0]} : {shreg[123:0], lanes});

    // ------------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            qspi_pkg::ST_IDLE:
                if (start_i)
                    next_state = (cs_delay_i == '0) ? qspi_pkg::ST_SHIFT
                                                    : qspi_pkg::ST_LEAD;
            qspi_pkg::ST_LEAD:
                if (ph_wrap && lead_cnt == cfg.cs_delay - 2'h1)
                    next_state = qspi_pkg::ST_SHIFT;
            qspi_pkg::ST_SHIFT:
                if (word_end)
                    next_state = qspi_pkg::ST_PUSH;
            qspi_pkg::ST_PUSH:
                if (push_ready)
                    next_state = last_word ? qspi_pkg::ST_END
                                           : qspi_pkg::ST_SHIFT;
            qspi_pkg::ST_END:
                next_state = qspi_pkg::ST_IDLE;
            default:
                next_state = qspi_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer and link flops
    // ------------------------------------------------------------------
    // own clock and select
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            state <= qspi_pkg::ST_IDLE;
            cs_b <= 1'b1;
            sclk <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cs_b <= (next_state == qspi_pkg::ST_IDLE) ||
                    (next_state == qspi_pkg::ST_END);
            sclk <= is_shift && !word_end && (ph_nxt >= low_len);
        end
    end

    // Config latch; changes mid-frame have no effect
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
            cfg <= '0;
        else if (start_ok)
            // length and count taken per frame
            cfg <= '{read_width_i, word_len_m1_i, word_cnt_m1_i, cs_delay_i,
                     serial_clock_divide_factor_i, word_irq_en_i,
                     frame_irq_en_i};
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i || is_idle || is_push)
            ph <= qspi_pkg::PH_RST;
        else
            ph <= ph_nxt;
    end

    // lead-in periods with clock held low
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i || !is_lead)
            lead_cnt <= qspi_pkg::LEAD_RST;
        else if (ph_wrap)
            lead_cnt <= lead_cnt + 2'h1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            shreg <= '0;
            bit_cnt <= qspi_pkg::BIT_RST;
        end
        else if (sample_now)
        begin
            // one, two or four bits per edge
            shreg <= shifted;
            bit_cnt <= word_end ? qspi_pkg::BIT_RST : bit_cnt + step;
        end
        else if (push_done)
            shreg <= '0;
    end

    // words counted within one select frame
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i || is_idle)
            word_cnt <= qspi_pkg::WCNT_RST;
        else if (push_done)
            word_cnt <= word_cnt + 12'h001;
    end

    // completion events gated by enables; reset folded in
    always_ff @(posedge sys_clk_i)
    begin
        word_irq <= rst_b_i && push_done && cfg.word_irq_en;
        frame_irq <= rst_b_i && push_done && last_word && cfg.frame_irq_en;
    end

    // ------------------------------------------------------------------
    // Word buffer; a full buffer parks the link with clock low
    // ------------------------------------------------------------------
    // words handed over as whole entries
    qspi_fifo
    #(
        .WIDTH(qspi_pkg::WORD_W),
        .DEPTH(FIFO_WORDS)
    )
    u_fifo
    (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(is_push),
        .in_ready_o(push_ready),
        .in_data_i(shreg),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );

    // Outputs
    assign busy_o = !is_idle;
    assign word_irq_o = word_irq;
    assign frame_irq_o = frame_irq;
    assign sclk_o = sclk;
    assign cs_b_o = cs_b;
    // only lane 0 driven, single width, low
    assign dq_o = 4'h0;
    assign dq_oe_o = {3'h0, single && (is_shift || is_push)};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [qspi_pkg::PH_W-1:0] hi_cnt;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i || !sclk)
            hi_cnt <= qspi_pkg::PH_RST;
        else
            hi_cnt <= hi_cnt + 9'h001;
    end

    AST_IDLE_QUIET: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        is_idle |-> cs_b_o && !sclk_o)
        else $error("Link not quiet in idle");
    AST_CLK_IDLE_LOW: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        cs_b_o |-> !sclk_o)
        else $error("Clock high without select");
    AST_START_SELECT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        start_ok |=> !cs_b_o && busy_o)
        else $error("Select not asserted after start");
    AST_LEAD_SILENT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        is_lead |-> !sclk_o && dq_oe_o == 4'h0 && !cs_b_o)
        else $error("Activity during lead-in");
    AST_WIDE_NO_DRIVE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !single |-> dq_oe_o == 4'h0)
        else $error("Data line driven in wide read");
    AST_SAMPLE_FALL: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        sample_now |-> sclk_o ##1 !sclk_o)
        else $error("Sample not on falling edge");
    AST_HIGH_PHASE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(sclk_o) && is_shift |-> $past(hi_cnt) + 9'h001 == high_len)
        else $error("Clock high phase wrong");
    AST_FRAME_END: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        push_done && last_word |=> cs_b_o ##1 is_idle)
        else $error("Frame not closed after last word");
    AST_WORD_EVENT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        push_done |=> word_irq_o == cfg.word_irq_en)
        else $error("Word event mismatch");
    AST_PUSH_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        is_push && !push_ready |=> is_push && $stable(shreg) && !sclk_o)
        else $error("Word lost while buffer full");

endmodule

// *** include/qspi_pkg.sv ***
// ----------------------------------------------------------------------
// Shared constants and types for the quad serial read engine
// ----------------------------------------------------------------------
package qspi_pkg;

    // Field widths of the software controls and datapath, and buffer depth
    localparam int DIV_W = 8;
    localparam int LEN_W = 7;
    localparam int CNT_W = 12;
    localparam int DLY_W = 2;
    localparam int WORD_W = 128;
    localparam int BIT_W = 8;
    localparam int PH_W = 9;
    localparam int FIFO_DEPTH = 8;

    // Read width encodings
    localparam logic [1:0] WIDTH_SINGLE = 2'h0;
    localparam logic [1:0] WIDTH_DUAL = 2'h1;
    localparam logic [1:0] WIDTH_QUAD = 2'h2;

    // Reset values of internal counters
    localparam logic [PH_W-1:0] PH_RST = 9'h000;
    localparam logic [BIT_W-1:0] BIT_RST = 8'h00;
    localparam logic [CNT_W-1:0] WCNT_RST = 12'h000;
    localparam logic [DLY_W-1:0] LEAD_RST = 2'h0;

    // Divide setting zero still needs two module clocks per period
    localparam logic [PH_W-1:0] MIN_PERIOD = 9'h002;

    // Frame sequencer states, one-hot
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_LEAD = 5'h02,
        ST_SHIFT = 5'h04,
        ST_PUSH = 5'h08,
        ST_END = 5'h10
    } seq_state_e;

    // Per-frame configuration, latched at start
    typedef struct packed
    {
        logic [1:0] width;
        logic [LEN_W-1:0] word_len_m1;
        logic [CNT_W-1:0] word_cnt_m1;
        logic [DLY_W-1:0] cs_delay;
        logic [DIV_W-1:0] div;
        logic word_irq_en;
        logic frame_irq_en;
    } frame_cfg_s;

    localparam int CFG_W = $bits(frame_cfg_s);

endpackage

// *** design/qspi_fifo.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Word FIFO with registered read data
// ----------------------------------------------------------------------
module qspi_fifo
#(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic out_valid;
    logic [WIDTH-1:0] out_data;

    // Handshake terms
    wire wr_en = in_valid_i && in_ready_o;
    wire rd_en = (cnt != '0) && (!out_valid || out_ready_i);

    assign in_ready_o = (cnt != (AW+1)'(DEPTH));
    assign out_valid_o = out_valid;
    assign out_data_o = out_data;

    // Storage array, no reset needed
    always_ff @(posedge sys_clk_i)
    begin
        if (wr_en)
        begin
            mem[wp] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= wr_en ? wp + 1'b1 : wp;
            rp <= rd_en ? rp + 1'b1 : rp;
            cnt <= cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end

    // Output register, head of the queue
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (rd_en)
        begin
            out_valid <= 1'b1;
            out_data <= mem[rp];
        end
        else if (out_ready_i)
        begin
            out_valid <= 1'b0;
        end
    end

endmodule

// *** testbench/qspi_flash_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Serial flash stand-in streaming a known nibble pattern
// ----------------------------------------------------------------------
module qspi_flash_model
(
    input wire logic sclk_i,
    input wire logic cs_b_i,
    output logic [3:0] dq_o,
    output logic mode_err_o
);
    logic [11:0] edge_cnt;

    // Pattern shared with the bench, every lane toggles
    function automatic logic [3:0] nib(input logic [11:0] n);
        nib = 4'(n * 7 + 3);
    endfunction

    initial
    begin
        edge_cnt = 12'h000;
        dq_o = 4'hF;
        mode_err_o = 1'b0;
    end

    always @(negedge cs_b_i)
    begin
        if (sclk_i !== 1'b0)
            mode_err_o = 1'b1;
        edge_cnt = 12'h000;
        dq_o = nib(12'h000);
    end

    always @(negedge sclk_i)
    begin
        if (cs_b_i === 1'b0)
        begin
            #1;
            edge_cnt = edge_cnt + 12'h001;
            dq_o = nib(edge_cnt);
        end
    end

    // Released lines flip so a stale value is never read as good
    always @(posedge cs_b_i)
    begin
        dq_o = ~dq_o;
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------------
    // Frame settings with expected clock phases in module clocks
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] width;
        logic [6:0] len_m1;
        logic [11:0] cnt_m1;
        logic [1:0] dly;
        logic [7:0] div;
        logic [7:0] hi;
        logic [7:0] lo;
    } row_s;
    localparam row_s ROWS [8] = '{
        '{2'h0, 7'h00, 12'h002, 2'h0, 8'h00, 8'h01, 8'h01},
        '{2'h1, 7'h0F, 12'h001, 2'h1, 8'h01, 8'h01, 8'h01},
        '{2'h2, 7'h7F, 12'h000, 2'h3, 8'h02, 8'h01, 8'h02},
        '{2'h3, 7'h1F, 12'h003, 2'h2, 8'h03, 8'h02, 8'h02},
        '{2'h0, 7'h07, 12'h000, 2'h1, 8'h04, 8'h02, 8'h03},
        '{2'h1, 7'h7F, 12'h001, 2'h0, 8'h05, 8'h03, 8'h03},
        '{2'h2, 7'h0B, 12'h004, 2'h3, 8'h06, 8'h03, 8'h04},
        '{2'h0, 7'h00, 12'hFFF, 2'h0, 8'h00, 8'h01, 8'h01}};
    localparam row_s STALL = '{2'h2, 7'h07, 12'h00B, 2'h0, 8'h01, 8'h01,
        8'h01};

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic wen = 1'b0;
    logic fen = 1'b0;
    logic rd_ready = 1'b1;
    logic busy, word_irq, frame_irq, rd_valid, sclk, cs_b, mode_err;
    logic [127:0] rd_data;
    logic [3:0] dq_o, dq_oe, fl_dq, dq_wire;
    row_s cur = ROWS[0];
    logic [127:0] got [$];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int hi_run, lead, falls, wirq, firq;

    always #5 sys_clk = ~sys_clk;

    // Single width: the controller owns the lowest line
    assign dq_wire = {fl_dq[3:1], dq_oe[0] ? dq_o[0] : fl_dq[0]};

    qspi_flash_model i_flash (.sclk_i(sclk), .cs_b_i(cs_b), .dq_o(fl_dq),
        .mode_err_o(mode_err));

    quad_spi_read_controller #(.FIFO_WORDS(8)) i_dut (.sys_clk_i(sys_clk),
        .rst_b_i(rst_b), .start_i(start), .read_width_i(cur.width),
        .word_len_m1_i(cur.len_m1), .word_cnt_m1_i(cur.cnt_m1),
        .cs_delay_i(cur.dly), .serial_clock_divide_factor_i(cur.div),
        .word_irq_en_i(wen), .frame_irq_en_i(fen), .busy_o(busy),
        .word_irq_o(word_irq), .frame_irq_o(frame_irq),
        .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
        .sclk_o(sclk), .cs_b_o(cs_b), .dq_i(dq_wire), .dq_o(dq_o),
        .dq_oe_o(dq_oe));

    // ------------------------------------------------------------------
    // Comparison, verdict and hang guard
    // ------------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Longest run is the 4096 word frame, about 12k clocks
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            fail_count++;
            summarize();
        end
    end

    // Link watcher, one step past the falling edge so that the bench's
    // own input changes of that edge are in place, no race on rd_ready
    always @(negedge sys_clk)
    begin
        #1;
        if (rst_b)
        begin
            if (!cs_b && !sclk && falls == 0 && hi_run == 0)
                lead++;
            if (sclk)
                hi_run++;
            else if (hi_run != 0)
            begin
                check(hi_run, cur.hi);
                hi_run = 0;
                falls++;
            end
            if (cs_b === 1'b1)
                check(sclk, 1'b0);
            check(dq_oe[3:1], 3'h0);
            check(dq_o, 4'h0);
            if (sclk)
                check(dq_oe[0], cur.width == 2'h0);
            wirq += int'(word_irq);
            firq += int'(frame_irq);
            if (rd_valid && rd_ready)
                got.push_back(rd_data);
        end
    end

    // Word the pattern should give; length kept a multiple of the width
    function automatic logic [127:0] exp_word(input row_s r, input int w);
        int k;
        int e;
        logic [3:0] nb;
        logic [127:0] v;
        k = (r.width == 2'h0) ? 1 : (r.width == 2'h1) ? 2 : 4;
        e = (int'(r.len_m1) + 1) / k;
        v = '0;
        for (int n = 0; n < e; n++)
        begin
            nb = i_flash.nib(12'(w * e + n));
            nb = (k == 1) ? {3'h0, nb[1]} : (k == 2) ? {2'h0, nb[1:0]} : nb;
            v = (v << k) | 128'(nb);
        end
        return v;
    endfunction

    // One frame; a stall run keeps the consumer away to fill the buffer
    task automatic run(input row_s r, input logic we, input logic fe,
        input logic stall);
        int e;
        e = (int'(r.len_m1) + 1) / ((r.width == 2'h0) ? 1 :
            (r.width == 2'h1) ? 2 : 4);
        hi_run = 0;
        lead = 0;
        falls = 0;
        wirq = 0;
        firq = 0;
        got.delete();
        cur = r;
        wen = we;
        fen = fe;
        rd_ready = !stall;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        @(negedge sys_clk);
        check(busy, 1'b1);
        check(cs_b, 1'b0);
        if (stall)
        begin
            repeat (200) @(negedge sys_clk);
            check(falls, 10 * e);
            check(cs_b, 1'b0);
            start = 1'b1;
            @(negedge sys_clk);
            start = 1'b0;
            rd_ready = 1'b1;
        end
        while (busy || got.size() <= int'(r.cnt_m1))
            @(negedge sys_clk);
        check(cs_b, 1'b1);
        check(lead, r.dly * (r.hi + r.lo) + r.lo);
        check(falls, (int'(r.cnt_m1) + 1) * e);
        check(wirq, we ? int'(r.cnt_m1) + 1 : 0);
        check(firq, fe);
        check(got.size(), int'(r.cnt_m1) + 1);
        for (int w = 0; w < got.size(); w++)
            check(got[w], exp_word(r, w));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        foreach (ROWS[i])
            run(ROWS[i], i != 1, i != 2, 1'b0);
        run(STALL, 1'b1, 1'b1, 1'b1);
        // Reset in mid-frame must drop the select within three clocks
        cur = ROWS[5];
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (30) @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({cs_b, sclk, busy, rd_valid}, 4'h8);
        rst_b = 1'b1;
        run(ROWS[6], 1'b1, 1'b1, 1'b0);
        check(mode_err, 1'b0);
        summarize();
    end
endmodule
